/* File: include/conv_pkg.sv */
// constants, types and field layout shared by the converter control block
// assumes a single core clock; the serial pins are sampled, not clocked from
package conv_pkg;
	// word sizes and bit counts
	localparam int         WORD_BITS   = 24;        // control and coef word
	localparam int         TOP_BIT     = 23;        // first bit on the wire
	localparam logic [4:0] COUNT_FULL  = 5'h18;     // 24 clock pulses
	localparam logic [4:0] COUNT_SHORT = 5'h10;     // 16-bit data word
	localparam logic [4:0] COUNT_ONE   = 5'h01;     // counter step
	// background calibration: one output word every six measurements
	localparam int         BG_SLOTS     = 6;
	localparam logic [2:0] BG_ZERO_SLOT = 3'h0;     // shorted inputs
	localparam logic [2:0] BG_FULL_SLOT = 3'h1;     // reference
	localparam logic [2:0] BG_LAST      = 3'(BG_SLOTS - 1);
	localparam logic [2:0] SLOT_ONE     = 3'h1;

	typedef logic [WORD_BITS-1:0] word_t;

	// operating mode field codes
	typedef enum logic [2:0] {
		MODE_NORMAL     = 3'b000,
		MODE_SELF_CAL   = 3'b001,
		MODE_SYS_ZERO   = 3'b010,
		MODE_SYS_FULL   = 3'b011,
		MODE_SYS_OFFSET = 3'b100,
		MODE_BACKGROUND = 3'b101,
		MODE_ZERO_COEF  = 3'b110,
		MODE_FULL_COEF  = 3'b111
	} mode_t;

	// what the analog side is asked to measure
	typedef enum logic [1:0] {
		SRC_INPUT     = 2'b00,
		SRC_SHORTED   = 2'b01,
		SRC_REFERENCE = 2'b10
	} meas_src_t;

	// calibration sequencer states
	typedef enum logic [1:0] {
		ST_CONV = 2'b00,
		ST_ZERO = 2'b01,
		ST_FULL = 2'b10,
		ST_BACK = 2'b11
	} seq_state_t;

	// control word, most significant field first
	typedef struct packed {
		mode_t       mode;
		logic [2:0]  gain;
		logic        channel_select_bit;
		logic        power_down_bit;
		logic        output_length_bit;
		logic        excitation_bit;
		logic        burnout_current_bit;
		logic        polarity_bit;
		logic [11:0] filter_code;
	} ctrl_word_t;

	localparam ctrl_word_t CTRL_RESET = 24'h00_0000;
	localparam word_t      WORD_ZERO  = 24'h00_0000;

	// serial pins as one bundle for the synchroniser
	typedef struct packed {
		logic sclk;
		logic wr_fs_n;
		logic rd_fs_n;
		logic sel;
		logic sdi;
	} pins_t;
	localparam pins_t PINS_IDLE = 5'h1e;            // frames idle high
endpackage

/* File: rtl/adc_control_and_calibration_modes.sv */
// control register, serial port and mode control of the converter
// assumes the analog side supplies results on meas_valid/meas_word
// in this clock domain; serial pins are asynchronous and oversampled
`timescale 1ns/10ps
`default_nettype none
module adc_control_and_calibration_modes (
	input  wire logic                core_clk,             // 100 MHz
	input  wire logic                nrst,                 // async, low
	input  wire logic                serial_clock,         // host clock
	input  wire logic                write_frame_sync_n,   // write frame
	input  wire logic                read_frame_sync_n,    // read frame
	input  wire logic                register_select_line, // 0: control
	input  wire logic                serial_io_line_in,    // pin level
	output logic                     serial_io_line_out,   // pin drive
	output logic                     serial_io_line_oe,    // drive on
	output logic                     result_ready_n,       // result ready
	input  wire logic                meas_valid,           // result strobe
	input  wire conv_pkg::word_t     meas_word,            // result value
	output var conv_pkg::meas_src_t  meas_source,          // what to take
	output var conv_pkg::ctrl_word_t active_ctrl           // to front end
);
	import conv_pkg::*;

	// synchronised pins and their previous values
	pins_t      raw_pins;   // pins as a bundle
	pins_t      pins_s;     // after two flops
	logic       sclk_q;     // serial clock, one cycle older
	logic       wr_fs_q;    // write frame, one cycle older
	logic       rd_fs_q;    // read frame, one cycle older
	logic       sclk_rise;  // rising serial clock edge
	logic       sclk_fall;  // falling serial clock edge

	// write side
	logic       wr_fall;     // write frame begins
	logic       wr_rise;     // write frame ends
	logic       wr_take;     // take one data bit
	logic       wr_whole;    // frame ended with 24 bits taken
	logic [4:0] wcount;      // bits taken this frame
	logic       wsel;        // select line caught at frame start
	word_t      wshift;      // incoming word
	ctrl_word_t wr_word;     // incoming word seen as control fields
	logic       ctrl_commit; // load control register
	logic       coef_commit; // coefficient write of a whole word
	logic       zs_write;    // host writes zero-scale coef
	logic       fs_write;    // host writes full-scale coef

	// registers of the block
	ctrl_word_t ctrl;        // control register
	ctrl_word_t next_ctrl;   // its next value
	ctrl_word_t clear_ctrl;  // control with mode back to normal
	word_t      data_word;   // last conversion result
	word_t      zs_coef [2]; // zero-scale coef per channel
	word_t      fs_coef [2]; // full-scale coef per channel
	logic       ch;          // channel of coefficient access
	logic       next_ready_n;

	// read side
	logic       rd_fall;     // read frame begins
	logic       rd_active;   // drives the data line
	logic       rd_data_q;   // this frame reads the data register
	logic [4:0] rcount;      // bits shifted out
	logic [4:0] rlen;        // bits in this frame's word
	word_t      rshift;      // outgoing word
	logic       rd_shift;    // move to next bit
	logic       rd_is_data;  // select high reaches data register
	logic       coef_mode;   // select high reaches a coefficient
	word_t      rd_word;     // word chosen at frame start
	logic [4:0] rd_len;      // its length
	logic       read_done;   // last bit of a data word sent

	// sequencer strobes
	logic       zero_load;
	logic       full_load;
	logic       data_load;
	logic       cal_done;

	assign raw_pins = '{sclk: serial_clock,
		wr_fs_n: write_frame_sync_n, rd_fs_n: read_frame_sync_n,
		sel: register_select_line, sdi: serial_io_line_in};

	// every pin is asynchronous to core_clk
	pin_sync #(
		.WIDTH ($bits(pins_t)),
		.INIT  (PINS_IDLE)
	) u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.raw      (raw_pins),
		.synced   (pins_s)
	);

	// edge history, taken from the synchronised copies only
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sclk_q  <= 1'b1;
			wr_fs_q <= 1'b1;
			rd_fs_q <= 1'b1;
		end else begin
			sclk_q  <= pins_s.sclk;
			wr_fs_q <= pins_s.wr_fs_n;
			rd_fs_q <= pins_s.rd_fs_n;
		end
	end

	assign sclk_rise = pins_s.sclk & ~sclk_q;
	assign sclk_fall = ~pins_s.sclk & sclk_q;

	// write decode: bits only while the frame is low, 24 at most
	assign wr_fall  = wr_fs_q & ~pins_s.wr_fs_n;
	assign wr_rise  = ~wr_fs_q & pins_s.wr_fs_n;
	assign wr_take  = ~pins_s.wr_fs_n & ~wr_fall & sclk_rise &
		(wcount != COUNT_FULL);
	assign wr_whole = wr_rise & (wcount == COUNT_FULL);
	assign ctrl_commit = wr_whole & ~wsel;
	assign coef_commit = wr_whole & wsel;
	assign zs_write = coef_commit & (ctrl.mode == MODE_ZERO_COEF);
	assign fs_write = coef_commit & (ctrl.mode == MODE_FULL_COEF);

	// shift in msb first; a short frame never reaches the commit
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wcount <= 5'h00;
			wsel   <= 1'b0;
			wshift <= WORD_ZERO;
		end else if (wr_fall) begin
			wcount <= 5'h00;
			wsel   <= pins_s.sel;
		end else if (wr_take) begin
			wcount <= wcount + COUNT_ONE;
			wshift <= {wshift[TOP_BIT-1:0], pins_s.sdi};
		end
	end

	// control register; a host write beats a calibration finishing
	// named view of the shifter, so fields are selected from a signal
	assign wr_word    = ctrl_word_t'(wshift);
	assign clear_ctrl = ctrl_word_t'({MODE_NORMAL, ctrl[20:0]});
	assign next_ctrl  = ctrl_commit ? wr_word :
		cal_done ? clear_ctrl : ctrl;
	assign active_ctrl = ctrl;
	assign ch = ctrl.channel_select_bit;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= CTRL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// mode sequencing lives in its own module
	cal_sequencer u_seq (
		.core_clk    (core_clk),
		.nrst        (nrst),
		.start       (ctrl_commit),
		.mode        (wr_word.mode),
		.meas_valid  (meas_valid & ~ctrl.power_down_bit),
		.meas_source (meas_source),
		.zero_load   (zero_load),
		.full_load   (full_load),
		.data_load   (data_load),
		.cal_done    (cal_done)
	);

	// coefficients: a host write wins over an automatic update
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			zs_coef[0] <= WORD_ZERO;
			zs_coef[1] <= WORD_ZERO;
			fs_coef[0] <= WORD_ZERO;
			fs_coef[1] <= WORD_ZERO;
		end else begin
			if (zs_write) begin
				zs_coef[ch] <= wshift;
			end else if (zero_load) begin
				zs_coef[ch] <= meas_word;
			end
			if (fs_write) begin
				fs_coef[ch] <= wshift;
			end else if (full_load) begin
				fs_coef[ch] <= meas_word;
			end
		end
	end

	// data register and ready; a new result beats the read release
	assign next_ready_n = (data_load | cal_done) ? 1'b0 :
		read_done ? 1'b1 : result_ready_n;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			data_word      <= WORD_ZERO;
			result_ready_n <= 1'b1;
		end else begin
			result_ready_n <= next_ready_n;
			if (data_load) begin
				data_word <= meas_word;
			end
		end
	end

	// read decode: word and length fixed at the frame's falling edge
	assign rd_fall    = rd_fs_q & ~pins_s.rd_fs_n;
	assign coef_mode  = ctrl.mode == MODE_ZERO_COEF ||
		ctrl.mode == MODE_FULL_COEF;
	assign rd_is_data = pins_s.sel & ~coef_mode;
	assign rd_word = !pins_s.sel ? word_t'(ctrl) :
		(ctrl.mode == MODE_ZERO_COEF) ? zs_coef[ch] :
		(ctrl.mode == MODE_FULL_COEF) ? fs_coef[ch] :
		data_word;
	// a 16-bit data word is the top of the result; others are 24
	assign rd_len = (rd_is_data & ~ctrl.output_length_bit) ?
		COUNT_SHORT : COUNT_FULL;
	assign rd_shift  = rd_active & sclk_fall & ~pins_s.rd_fs_n &
		(rcount != rlen);
	assign read_done = rd_shift & rd_data_q &
		(rcount == rlen - COUNT_ONE);

	// output shifter; the line stays undriven outside a read frame
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rd_active <= 1'b0;
			rd_data_q <= 1'b0;
			rcount    <= 5'h00;
			rlen      <= COUNT_FULL;
			rshift    <= WORD_ZERO;
		end else if (rd_fall) begin
			rd_active <= 1'b1;
			rd_data_q <= rd_is_data;
			rcount    <= 5'h00;
			rlen      <= rd_len;
			rshift    <= rd_word;
		end else if (pins_s.rd_fs_n) begin
			rd_active <= 1'b0;
		end else if (rd_shift) begin
			rcount <= rcount + COUNT_ONE;
			rshift <= {rshift[TOP_BIT-1:0], 1'b0};
		end
	end

	assign serial_io_line_out = rshift[TOP_BIT];
	assign serial_io_line_oe  = rd_active;

	// checks on the register and port behaviour
	short_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(wr_rise && wcount != COUNT_FULL && !cal_done) |=> $stable(ctrl)
	) else $error("control changed by a short write");
	extra_clk_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(wcount == COUNT_FULL && !wr_fall) |=> $stable(wshift)
	) else $error("bit after the 24th was taken");
	ctrl_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
		ctrl_commit |=> word_t'(ctrl) == $past(wshift)
	) else $error("control write not loaded");
	mode_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(cal_done && !ctrl_commit) |=>
			(ctrl.mode == MODE_NORMAL && !result_ready_n)
	) else $error("calibration end not signalled");
	ready_fall_a: assert property (@(posedge core_clk) disable iff (!nrst)
		data_load |=> !result_ready_n && data_word == $past(meas_word)
	) else $error("new result not flagged");
	ready_rise_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(read_done && !data_load && !cal_done) |=> result_ready_n
	) else $error("ready not released after read");
	coef_write_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(zs_write && !ctrl_commit) |=> zs_coef[ch] == $past(wshift)
	) else $error("zero-scale coefficient not written");
	oe_start_a: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(serial_io_line_oe) |-> $past(rd_fall)
	) else $error("data line driven before read frame");
	first_bit_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(rd_fall && !pins_s.sel) |=>
			serial_io_line_out == $past(ctrl[TOP_BIT])
	) else $error("control read not msb first");
endmodule
`default_nettype wire

/* File: rtl/cal_sequencer.sv */
// mode sequencer: steers measurements into coefficients or data
// assumes the analog side strobes meas_valid once per result
`timescale 1ns/10ps
`default_nettype none
module cal_sequencer (
	input  wire logic              core_clk,    // system clock
	input  wire logic              nrst,        // async reset, low
	input  wire logic              start,       // control word committed
	input  wire conv_pkg::mode_t   mode,        // mode of that word
	input  wire logic              meas_valid,  // measurement finished
	output var conv_pkg::meas_src_t meas_source, // what to measure now
	output logic                   zero_load,   // store zero-scale
	output logic                   full_load,   // store full-scale
	output logic                   data_load,   // publish a result
	output logic                   cal_done     // calibration finished
);
	import conv_pkg::*;

	seq_state_t state;       // current step
	seq_state_t next_state;  // step after this cycle
	logic       zero_short;  // zero step on shorted inputs
	logic       full_after;  // zero step is followed by full step
	logic       full_ref;    // full step on the reference
	logic [2:0] slot;        // background slot counter
	logic       in_back;     // background mode active
	logic       last_slot;   // slot that yields an output word

	assign in_back   = state == ST_BACK;
	assign last_slot = slot == BG_LAST;

	// source follows the step; background walks shorted, ref, input
	assign meas_source =
		(state == ST_ZERO) ? (zero_short ? SRC_SHORTED : SRC_INPUT) :
		(state == ST_FULL) ? (full_ref ? SRC_REFERENCE : SRC_INPUT) :
		(in_back && slot == BG_ZERO_SLOT) ? SRC_SHORTED :
		(in_back && slot == BG_FULL_SLOT) ? SRC_REFERENCE : SRC_INPUT;

	// result routing strobes
	assign zero_load = meas_valid & ((state == ST_ZERO) |
		(in_back & (slot == BG_ZERO_SLOT)));
	assign full_load = meas_valid & ((state == ST_FULL) |
		(in_back & (slot == BG_FULL_SLOT)));
	assign data_load = meas_valid & ((state == ST_CONV) |
		(in_back & last_slot));
	assign cal_done  = meas_valid & ((state == ST_FULL) |
		((state == ST_ZERO) & ~full_after));

	// a new command always wins over a finishing measurement
	always_comb begin
		next_state = state;
		if (start) begin
			unique case (mode)
				MODE_SELF_CAL, MODE_SYS_ZERO, MODE_SYS_OFFSET:
					next_state = ST_ZERO;
				MODE_SYS_FULL:   next_state = ST_FULL;
				MODE_BACKGROUND: next_state = ST_BACK;
				MODE_NORMAL, MODE_ZERO_COEF, MODE_FULL_COEF:
					next_state = ST_CONV;
			endcase
		end else if (meas_valid) begin
			unique case (state)
				ST_ZERO: next_state = full_after ? ST_FULL : ST_CONV;
				ST_FULL: next_state = ST_CONV;
				ST_CONV, ST_BACK: next_state = state;
			endcase
		end
	end

	// step register and the flags that shape the two-step sequences
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state      <= ST_CONV;
			zero_short <= 1'b0;
			full_after <= 1'b0;
			full_ref   <= 1'b0;
		end else begin
			state <= next_state;
			if (start) begin
				zero_short <= mode == MODE_SELF_CAL;
				full_after <= mode == MODE_SELF_CAL ||
					mode == MODE_SYS_OFFSET;
				full_ref   <= mode == MODE_SELF_CAL ||
					mode == MODE_SYS_OFFSET;
			end
		end
	end

	// background slots: six measurements per published word
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			slot <= BG_ZERO_SLOT;
		end else if (start) begin
			slot <= BG_ZERO_SLOT;
		end else if (in_back && meas_valid) begin
			slot <= last_slot ? BG_ZERO_SLOT : slot + SLOT_ONE;
		end
	end

	bg_wrap_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(in_back && data_load && !start) |=> slot == BG_ZERO_SLOT
	) else $error("background word not on sixth slot");
	self_short_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(start && mode == MODE_SELF_CAL) |=> meas_source == SRC_SHORTED
	) else $error("self cal zero step not on shorted input");
endmodule
`default_nettype wire

/* File: rtl/pin_sync.sv */
// two-flop synchroniser for a bundle of asynchronous pins
// assumes each bit is independent; no word is carried across
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int               WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT  = '0
) (
	input  wire logic             core_clk, // sampling clock
	input  wire logic             nrst,     // async reset, active low
	input  wire logic [WIDTH-1:0] raw,      // pins from outside
	output logic      [WIDTH-1:0] synced    // safe to use
);
	logic [WIDTH-1:0] stage1; // first stage, read only by stage two

	// reset to the idle levels so no false edge appears at release
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			stage1 <= INIT;
			synced <= INIT;
		end else begin
			stage1 <= raw;
			synced <= stage1;
		end
	end
endmodule
`default_nettype wire

/* File: tb/adc_control_and_calibration_modes_bench.sv */
// self-checking bench for the converter control block
// assumes the host model paces the pins; results are pulsed in directly
`timescale 1ns/10ps
`default_nettype none
module adc_control_and_calibration_modes_bench;
	import conv_pkg::*;
	logic       core_clk, nrst, meas_valid, sclk, wr_n, rd_n, sel, out, oe;
	logic       rdy_n;     // result ready, low active
	wire logic  line;      // data pin
	word_t      meas_word; // result value
	meas_src_t  src;       // requested source
	ctrl_word_t ctrl;      // live control word
	word_t      r, zc, fc; // last read; expected channel 1 coefficients
	int         n_errors, n_checks;
	// base word: mode 000, gain 010, channel 1, 16-bit data, filter msb 0
	localparam ctrl_word_t BASE = 24'h0A_0707;
	adc_control_and_calibration_modes DUT (
		.core_clk(core_clk), .nrst(nrst), .serial_clock(sclk),
		.write_frame_sync_n(wr_n), .read_frame_sync_n(rd_n),
		.register_select_line(sel), .serial_io_line_in(line),
		.serial_io_line_out(out), .serial_io_line_oe(oe),
		.result_ready_n(rdy_n), .meas_valid(meas_valid),
		.meas_word(meas_word), .meas_source(src), .active_ctrl(ctrl));
	host_port_model host (.core_clk(core_clk), .dev_oe(oe), .dev_out(out),
		.sclk(sclk), .wr_n(wr_n), .rd_n(rd_n), .sel(sel), .line(line));
	always #5 core_clk = ~core_clk;
	task automatic end_sim();
		if (n_errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask
	// one-cycle result strobe, then let the answer land
	task automatic pulse(input word_t v);
		meas_word = v;
		meas_valid = 1'b1;
		@(negedge core_clk);
		meas_valid = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask
	// select a channel's coefficients and read both back as 24 bits
	task automatic chk_coef(input logic ch, input word_t ez, input word_t ef);
		ctrl_word_t w;
		w = BASE;
		w.channel_select_bit = ch;
		w.mode = MODE_ZERO_COEF;
		host.write_word(1'b0, {8'h00, w}, 24);
		host.read_word(1'b1, 24, r);
		chk("zero coefficient", ez, r);
		w.mode = MODE_FULL_COEF;
		host.write_word(1'b0, {8'h00, w}, 24);
		host.read_word(1'b1, 24, r);
		chk("full coefficient", ef, r);
	endtask
	task automatic t_reset();
		chk("control at reset", 24'h00_0000, ctrl);
		chk("ready at reset", 24'h00_0001, {23'h0, rdy_n});
		chk("drive at reset", 24'h00_0000, {23'h0, oe});
	endtask
	// a whole control write and its read back, then short and overlong writes
	task automatic t_ctrl();
		host.write_word(1'b0, 32'h0014_A123, 24);
		chk("control word", 24'h14_A123, ctrl);
		chk("gain field", 24'h00_0005, {21'h0, ctrl.gain});
		chk("word length", 24'h00_0001, {23'h0, ctrl.output_length_bit});
		chk("filter code", 24'h00_0123, {12'h0, ctrl.filter_code});
		host.read_word(1'b0, 24, r);
		chk("control read", 24'h14_A123, r);
		host.write_word(1'b0, 32'h0055_5555, 23);
		chk("short write", 24'h14_A123, ctrl);
		host.write_word(1'b0, {2'h0, BASE, 6'h2A}, 30);
		chk("long write", BASE, ctrl);
	endtask
	// a result lowers ready; a 16-bit data read returns it and raises ready
	task automatic t_data();
		pulse(24'hA5_C3E1);
		chk("ready on result", 24'h00_0000, {23'h0, rdy_n});
		host.read_word(1'b1, 16, r);
		chk("data word", 24'h00_A5C3, r);
		chk("ready after read", 24'h00_0001, {23'h0, rdy_n});
		chk("drive after read", 24'h00_0000, {23'h0, oe});
		// powered down: a result strobe must not be taken
		host.write_word(1'b0, {8'h00, BASE | 24'h01_0000}, 24);
		pulse(24'h5A_5A5A);
		chk("ready in power-down", 24'h00_0001, {23'h0, rdy_n});
	endtask
	// one calibration mode: sources in order, completion, coefficients
	task automatic t_cal(input mode_t m, input word_t z, input word_t f);
		ctrl_word_t w;
		logic two;
		w = BASE;
		w.mode = m;
		two = (m == MODE_SELF_CAL) || (m == MODE_SYS_OFFSET);
		host.write_word(1'b0, {8'h00, w}, 24);
		chk("first source", (m == MODE_SELF_CAL) ? 24'h1 : 24'h0, {22'h0, src});
		pulse((m == MODE_SYS_FULL) ? f : z);
		if (two) begin
			chk("second source", 24'h00_0002, {22'h0, src});
			pulse(f);
		end
		if (m != MODE_SYS_FULL) zc = z;
		if (m != MODE_SYS_ZERO) fc = f;
		chk("mode after cal", 24'h00_0000, {21'h0, ctrl.mode});
		chk("ready after cal", 24'h00_0000, {23'h0, rdy_n});
		host.read_word(1'b1, 16, r);
		chk("ready released", 24'h00_0001, {23'h0, rdy_n});
		chk_coef(1'b1, zc, fc);
	endtask
	// host loads channel 0 coefficients; a 20-bit write must not land
	task automatic t_coef_write();
		ctrl_word_t w;
		w = BASE;
		w.channel_select_bit = 1'b0;
		w.mode = MODE_ZERO_COEF;
		host.write_word(1'b0, {8'h00, w}, 24);
		host.write_word(1'b1, 32'h003C_5A96, 24);
		host.write_word(1'b1, 32'h000F_FFFF, 20);
		w.mode = MODE_FULL_COEF;
		host.write_word(1'b0, {8'h00, w}, 24);
		host.write_word(1'b1, 32'h0069_1E2D, 24);
		chk_coef(1'b0, 24'h3C_5A96, 24'h69_1E2D);
		chk_coef(1'b1, zc, fc);
	endtask
	// six slots: shorted, reference, four inputs; only the sixth publishes
	task automatic t_background();
		ctrl_word_t w;
		w = BASE;
		w.channel_select_bit = 1'b0;
		w.mode = MODE_BACKGROUND;
		host.write_word(1'b0, {8'h00, w}, 24);
		for (int i = 0; i < 6; i++) begin
			chk("slot source", (i < 2) ? 24'(i + 1) : 24'h0, {22'h0, src});
			pulse(word_t'(24'h11_1111 * (i + 1)));
			chk("slot ready", (i == 5) ? 24'h0 : 24'h1, {23'h0, rdy_n});
		end
		host.read_word(1'b1, 16, r);
		chk("background data", 24'h00_6666, r);
		chk_coef(1'b0, 24'h11_1111, 24'h22_2222);
	endtask
	initial begin
		core_clk = 1'b0;
		nrst = 1'b0;
		meas_valid = 1'b0;
		meas_word = WORD_ZERO;
		n_errors = 0;
		n_checks = 0;
		zc = WORD_ZERO;
		fc = WORD_ZERO;
		repeat (2) @(negedge core_clk);
		nrst = 1'b1;
		@(negedge core_clk);
		t_reset();
		t_ctrl();
		t_data();
		t_cal(MODE_SELF_CAL, 24'h12_3456, 24'hED_CBA9);
		t_cal(MODE_SYS_ZERO, 24'h21_4365, 24'hDE_BC9A);
		t_cal(MODE_SYS_FULL, 24'h30_5070, 24'hCF_AF8F);
		t_cal(MODE_SYS_OFFSET, 24'h0F_1E2D, 24'hF0_E1D2);
		t_coef_write();
		t_background();
		end_sim();
	end
	// about 19k cycles expected; a hang is cut well beyond that
	initial begin
		repeat (90000) @(posedge core_clk);
		n_errors++;
		end_sim();
	end
endmodule
`default_nettype wire

/* File: tb/host_port_model.sv */
// host side of the framed serial port: whole and cut words, both ways
// assumes the device oversamples the pins with core_clk; we move on its fall
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
	input  wire logic core_clk, // pacing clock
	input  wire logic dev_oe,   // device drives the data pin
	input  wire logic dev_out,  // device data level
	output logic      sclk,     // serial clock, idles high
	output logic      wr_n,     // write frame
	output logic      rd_n,     // read frame
	output logic      sel,      // register select
	output wire logic line      // resolved data pin level
);
	logic drv;    // last level put out by the host
	logic drv_en; // host drives the pin
	// a released pin shows the inverse of the last bit, so stale data fails
	assign line = dev_oe ? dev_out : (drv_en ? drv : ~drv);
	// pins idle with frames high from time zero
	initial begin
		sclk = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		sel = 1'b0;
		drv = 1'b0;
		drv_en = 1'b0;
	end
	// half of the 160 ns serial period
	task automatic half();
		repeat (8) @(negedge core_clk);
	endtask
	// send the low n bits of w, msb first, data valid on sclk rise
	task automatic write_word(input logic s, input logic [31:0] w, input int n);
		sel = s;
		@(negedge core_clk);
		wr_n = 1'b0;
		drv_en = 1'b1;
		half();
		for (int i = n - 1; i >= 0; i--) begin
			sclk = 1'b0;
			drv = w[i];
			half();
			sclk = 1'b1;
			half();
		end
		wr_n = 1'b1;
		drv_en = 1'b0;
		half();
	endtask
	// take n bits, msb first; each bit sampled while sclk is high
	task automatic read_word(input logic s, input int n, output logic [23:0] r);
		sel = s;
		@(negedge core_clk);
		rd_n = 1'b0;
		r = '0;
		half();
		for (int i = 0; i < n; i++) begin
			r = {r[22:0], line};
			sclk = 1'b0;
			half();
			sclk = 1'b1;
			half();
		end
		rd_n = 1'b1;
		half();
	endtask
endmodule
`default_nettype wire
